// >>> rtl/hmsc_break_det.sv
// Break detector on the receive line, asks for full reset
`timescale 1ns/1ps
`default_nettype none
module hmsc_break_det
  import hmsc_pkg::*;
#(
  parameter int BREAK_LEN = BREAK_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic rx_low,
  output logic      break_reset
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_break_reset;

  always_comb begin
    next_count       = count;
    next_break_reset = 1'b0;
    if (!rx_low) begin
      next_count = 32'h0;
    end else if (count > 32'(BREAK_LEN)) begin
      next_break_reset = 1'b1;
    end else begin
      next_count = count + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count       <= 32'h0;
      break_reset <= 1'b0;
    end else begin
      count       <= next_count;
      break_reset <= next_break_reset;
    end
  end
endmodule // hmsc_break_det
`default_nettype wire

// >>> rtl/hmsc_osc_div.sv
// Divided oscillator clock output, 8/16/24/48 MHz of a 48 MHz source
`timescale 1ns/1ps
`default_nettype none
module hmsc_osc_div
  import hmsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  input  wire logic       osc_in,
  output logic            osc_out
);
  // Source assumed synchronous to clk as a toggling enable
  logic [2:0] phase;
  logic [2:0] next_phase;
  logic [2:0] limit;
  logic       next_out;

  always_comb begin
    // Period minus one, in source ticks: 5, 2, 1 or 0
    case (sel)
      2'h0:    limit = 3'h5;
      2'h1:    limit = 3'h2;
      2'h2:    limit = 3'h1;
      default: limit = 3'h0;
    endcase
    next_phase = phase;
    next_out   = osc_out;
    if (!enable) begin
      next_phase = 3'h0;
      next_out   = 1'b0;
    end else if (limit == 3'h0) begin
      next_out = osc_in; // Full rate passes the source through
    end else if (osc_in) begin
      next_phase = (phase >= limit) ? 3'h0 : phase + 3'h1;
      // High for first half of period; odd divide runs long high
      next_out   = (next_phase <= (limit >> 1));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase   <= 3'h0;
      osc_out <= 1'b0;
    end else begin
      phase   <= next_phase;
      osc_out <= next_out;
    end
  end
endmodule // hmsc_osc_div
`default_nettype wire

// >>> rtl/hmsc_pkg.sv
// Package of constants and types for the host modem signal control block
package hmsc_pkg;
  localparam int          CLK_HZ            = 100_000_000;
  localparam int          MS_CYCLES         = CLK_HZ / 1000;
  localparam int          BREAK_MS          = 100;
  localparam int          BREAK_CYCLES      = BREAK_MS * MS_CYCLES;
  localparam int          RETRY_MIN_MS      = 100;
  localparam int          RETRY_MAX_MS      = 15000;
  localparam logic [15:0] RETRY_RESET_MS    = 16'h07d0;
  localparam logic [15:0] DROP_RESET_MS     = 16'h0000;
  localparam logic [7:0]  ADR_CTRL          = 8'h00;
  localparam logic [7:0]  ADR_MAP           = 8'h04;
  localparam logic [7:0]  ADR_RETRY         = 8'h08;
  localparam logic [7:0]  ADR_DROP          = 8'h0c;
  localparam logic [7:0]  ADR_CMD           = 8'h10;
  localparam logic [7:0]  ADR_STATUS        = 8'h14;
  localparam logic [7:0]  ADR_IRQ_STAT      = 8'h18;
  localparam logic [7:0]  ADR_IRQ_EN        = 8'h1c;
  localparam logic [7:0]  ADR_IRQ_CLR       = 8'h20;
  localparam logic [7:0]  ADR_GPIO          = 8'h24;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
  localparam logic [31:0] MAP_RESET         = 32'h0000_e4e4;
  localparam int          CTRL_RING_OUT     = 0;
  localparam int          CTRL_CARR_OUT     = 1;
  localparam int          CTRL_PURE_HOST    = 2;
  localparam int          CTRL_CABLE        = 3;
  localparam int          CTRL_DROP_MODE    = 4;
  localparam int          CTRL_PEER_SET     = 5;
  localparam int          CTRL_MASTER       = 6;
  localparam int          CTRL_OSC_EN       = 7;
  localparam int          CTRL_OSC_SEL      = 8;
  localparam int          CMD_CONNECT       = 0;
  localparam int          CMD_PAIRABLE      = 1;
  localparam int          CMD_DISCOVER      = 2;
  localparam int          CMD_ANSWER        = 3;
  localparam int          CMD_HANGUP        = 4;
  localparam int          CMD_ENTER_DATA    = 5;
  localparam int          EV_ERROR          = 0;
  localparam int          EV_RING           = 1;
  localparam int          EV_CONNECT        = 2;
  localparam int          EV_DROP           = 3;
  localparam int          EV_CMD_STATE      = 4;
  localparam int          EV_RETRY          = 5;
  localparam int          NUM_EV            = 6;

  typedef enum logic [2:0] {
    HMSC_IDLE    = 3'b000,
    HMSC_RINGING = 3'b001,
    HMSC_DIALING = 3'b010,
    HMSC_DATA    = 3'b011,
    HMSC_COMMAND = 3'b100,
    HMSC_WAIT    = 3'b101
  } hmsc_state_t;

  function automatic logic [31:0] hmsc_ms_to_cycles(input logic [15:0] ms);
    hmsc_ms_to_cycles = 32'(ms) * 32'(MS_CYCLES);
  endfunction
endpackage

// >>> rtl/hmsc_top.sv
// Modem control and status line logic with Wishbone register slave
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module hmsc_top
  import hmsc_pkg::*;
#(
  parameter int BREAK_LEN = BREAK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        host_presence_pin_n,
  input  wire logic        clear_to_send_n,
  output logic             request_to_send_n,
  input  wire logic        rx_line,
  input  wire logic        rx_room,
  input  wire logic        serial_ring_line_i,
  output logic             serial_ring_line_o,
  output logic             serial_ring_line_oe_n,
  input  wire logic        serial_carrier_line_i,
  output logic             serial_carrier_line_o,
  output logic             serial_carrier_line_oe_n,
  input  wire logic        gp_or_terminal_ready_pin_i,
  output logic             gp_or_terminal_ready_pin_o,
  output logic             gp_or_terminal_ready_pin_oe_n,
  input  wire logic        link_incoming,
  input  wire logic [7:0]  link_incoming_id,
  input  wire logic        link_up,
  input  wire logic        link_fail,
  input  wire logic [3:0]  remote_bits,
  output logic      [3:0]  local_bits,
  output logic             link_open,
  output logic             link_close,
  output logic             link_accept,
  output logic             break_forward,
  output logic             tx_allowed,
  input  wire logic        osc_tick,
  output logic             osc_out,
  output logic             irq,
  output logic             full_reset
);
  // Pin sync, two flops; only stage two is read
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
    end else begin
      sync1 <= {host_presence_pin_n, clear_to_send_n, rx_line, serial_ring_line_i, serial_carrier_line_i};
      sync2 <= sync1;
    end
  end
  logic dsr_on;
  logic cts_on;
  logic ri_in;
  logic dcd_in;
  assign dsr_on = ~sync2[4];
  assign cts_on = ~sync2[3];
  assign ri_in  = ~sync2[1];
  assign dcd_in = ~sync2[0];

  // Registers
  logic [31:0]      ctrl;
  logic [31:0]      map;
  logic [15:0]      retry_ms;
  logic [15:0]      drop_ms;
  logic [7:0]       peer_id;
  logic [7:0]       gpio;
  logic [NUM_EV-1:0] ev_stat;
  logic [NUM_EV-1:0] ev_en;
  logic [31:0]      next_ctrl;
  logic [31:0]      next_map;
  logic [15:0]      next_retry_ms;
  logic [15:0]      next_drop_ms;
  logic [7:0]       next_peer_id;
  logic [7:0]       next_gpio;
  logic [NUM_EV-1:0] next_ev_stat;
  logic [NUM_EV-1:0] next_ev_en;
  logic [NUM_EV-1:0] ev;
  logic [31:0]      next_dat;
  logic             next_ack;
  logic             wr;
  logic [5:0]       cmd;

  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign cmd = (wr && wb_adr_i == ADR_CMD) ? wb_dat_i[5:0] : 6'h0;

  // Connection state
  hmsc_state_t state;
  hmsc_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [31:0] retry_cycles;
  logic [15:0] retry_clamped;
  logic        connected;
  logic        dsr_prev;
  logic        next_open;
  logic        next_close;
  logic        next_accept;
  logic        peer_ok;

  always_comb begin
    if (retry_ms < 16'(RETRY_MIN_MS))
      retry_clamped = 16'(RETRY_MIN_MS);
    else if (retry_ms > 16'(RETRY_MAX_MS))
      retry_clamped = 16'(RETRY_MAX_MS);
    else
      retry_clamped = retry_ms;
  end
  assign retry_cycles = hmsc_ms_to_cycles(retry_clamped);
  assign connected    = (state == HMSC_DATA) || (state == HMSC_COMMAND);
  assign peer_ok      = !ctrl[CTRL_PEER_SET] || (link_incoming_id == peer_id);

  always_comb begin
    next_state  = state;
    next_timer  = timer;
    next_open   = 1'b0;
    next_close  = 1'b0;
    next_accept = 1'b0;
    ev          = '0;
    case (state)
      HMSC_IDLE: begin
        if (link_incoming && peer_ok) begin
          next_state = HMSC_RINGING;
          ev[EV_RING] = 1'b1;
        end else if (cmd[CMD_CONNECT] || cmd[CMD_PAIRABLE] || cmd[CMD_DISCOVER]) begin
          if (!dsr_on) begin
            ev[EV_ERROR] = 1'b1;
          end else if (cmd[CMD_CONNECT]) begin
            next_state = HMSC_DIALING;
            next_open  = 1'b1;
          end
        end else if (ctrl[CTRL_CABLE] && ctrl[CTRL_MASTER] && dsr_on) begin
          next_state = HMSC_DIALING;
          next_open  = 1'b1;
        end
      end
      HMSC_RINGING: begin
        if (cmd[CMD_ANSWER]) begin
          next_state  = HMSC_DATA;
          next_accept = 1'b1;
          ev[EV_CONNECT] = 1'b1;
        end else if (cmd[CMD_HANGUP] || !link_incoming) begin
          next_state = HMSC_IDLE;
          next_close = 1'b1;
        end else if (ctrl[CTRL_CABLE] && !ctrl[CTRL_MASTER]) begin
          next_state  = HMSC_DATA;
          next_accept = 1'b1;
          ev[EV_CONNECT] = 1'b1;
        end
      end
      HMSC_DIALING: begin
        if (link_up) begin
          next_state = HMSC_DATA;
          ev[EV_CONNECT] = 1'b1;
        end else if (link_fail || cmd[CMD_HANGUP]) begin
          next_state = (ctrl[CTRL_CABLE] && !cmd[CMD_HANGUP]) ? HMSC_WAIT : HMSC_IDLE;
          next_timer = 32'h0;
        end
      end
      HMSC_WAIT: begin
        next_timer = timer + 32'h1;
        if (timer >= retry_cycles - 32'h1) begin
          next_state = HMSC_DIALING;
          next_open  = 1'b1;
          ev[EV_RETRY] = 1'b1;
        end
      end
      HMSC_DATA: begin
        if (!dsr_on && (ctrl[CTRL_DROP_MODE] || !ctrl[CTRL_CABLE])) begin
          next_state = HMSC_COMMAND;
          next_timer = 32'h0;
          ev[EV_CMD_STATE] = 1'b1;
        end
      end
      HMSC_COMMAND: begin
        next_timer = dsr_on ? 32'h0 : timer + 32'h1;
        if (cmd[CMD_ENTER_DATA] && dsr_on) begin
          next_state = HMSC_DATA;
        end else if (cmd[CMD_HANGUP] ||
                     (!dsr_on && drop_ms != 16'h0 && timer >= hmsc_ms_to_cycles(drop_ms))) begin
          next_state = HMSC_IDLE;
          next_close = 1'b1;
          ev[EV_DROP] = 1'b1;
        end
      end
      default: next_state = HMSC_IDLE;
    endcase
    if (connected && !link_up && state != HMSC_DIALING) begin
      // Link lost: cable mode master retries, else idle
      next_state = ctrl[CTRL_CABLE] && ctrl[CTRL_MASTER] ? HMSC_WAIT : HMSC_IDLE;
      next_timer = 32'h0;
      ev[EV_DROP] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= HMSC_IDLE;
      timer       <= 32'h0;
      link_open   <= 1'b0;
      link_close  <= 1'b0;
      link_accept <= 1'b0;
      dsr_prev    <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      link_open   <= next_open;
      link_close  <= next_close;
      link_accept <= next_accept;
      dsr_prev    <= dsr_on;
    end
  end

  // Local modem lines; map register routes remote bits
  logic [3:0] next_local;
  logic       next_ri;
  logic       next_dcd;
  logic       next_dtr;
  always_comb begin
    next_local = '0;
    for (int i = 0; i < 4; i++) begin
      next_local[map[2*i +: 2]] = next_local[map[2*i +: 2]] | remote_bits[i];
    end
    next_ri  = (state == HMSC_RINGING) | (map[8] & next_local[3]);
    next_dcd = connected | (map[9] & next_local[2]);
    next_dtr = ctrl[CTRL_PURE_HOST] ? connected : gpio[0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      local_bits                 <= 4'h0;
      serial_ring_line_o         <= 1'b1;
      serial_carrier_line_o      <= 1'b1;
      gp_or_terminal_ready_pin_o <= 1'b1;
      request_to_send_n          <= 1'b1;
      tx_allowed                 <= 1'b0;
    end else begin
      local_bits                 <= next_local;
      serial_ring_line_o         <= ~next_ri;
      serial_carrier_line_o      <= ~next_dcd;
      gp_or_terminal_ready_pin_o <= ~next_dtr;
      request_to_send_n          <= ~rx_room;
      tx_allowed                 <= cts_on;
    end
  end
  assign serial_ring_line_oe_n         = ~ctrl[CTRL_RING_OUT];
  assign serial_carrier_line_oe_n      = ~ctrl[CTRL_CARR_OUT];
  assign gp_or_terminal_ready_pin_oe_n = ~(ctrl[CTRL_PURE_HOST] | gpio[1]);
  assign break_forward                 = 1'b0;

  hmsc_break_det #(
    .BREAK_LEN (BREAK_LEN)
  ) u_break (
    .clk         (clk),
    .reset       (reset),
    .rx_low      (~sync2[2]),
    .break_reset (full_reset)
  );

  hmsc_osc_div u_osc (
    .clk     (clk),
    .reset   (reset),
    .enable  (ctrl[CTRL_OSC_EN]),
    .sel     (ctrl[CTRL_OSC_SEL +: 2]),
    .osc_in  (osc_tick),
    .osc_out (osc_out)
  );

  // Register file
  always_comb begin
    next_ctrl     = ctrl;
    next_map      = map;
    next_retry_ms = retry_ms;
    next_drop_ms  = drop_ms;
    next_peer_id  = peer_id;
    next_gpio     = gpio;
    next_ev_en    = ev_en;
    next_ev_stat  = ev_stat;
    if (wr) begin
      case (wb_adr_i)
        ADR_CTRL:   next_ctrl     = wb_dat_i;
        ADR_MAP:    next_map      = wb_dat_i;
        ADR_RETRY:  next_retry_ms = wb_dat_i[15:0];
        ADR_DROP:   begin
          next_drop_ms = wb_dat_i[15:0];
          next_peer_id = wb_dat_i[23:16];
        end
        ADR_IRQ_EN: next_ev_en    = wb_dat_i[NUM_EV-1:0];
        ADR_IRQ_CLR: next_ev_stat = ev_stat & ~wb_dat_i[NUM_EV-1:0];
        ADR_GPIO:   next_gpio     = wb_dat_i[7:0];
        default:    next_gpio     = gpio;
      endcase
    end
    next_ev_stat = next_ev_stat | ev; // Set wins over clear
    next_dat = 32'h0;
    case (wb_adr_i)
      ADR_CTRL:     next_dat = ctrl;
      ADR_MAP:      next_dat = map;
      ADR_RETRY:    next_dat = {16'h0, retry_ms};
      ADR_DROP:     next_dat = {8'h0, peer_id, drop_ms};
      ADR_STATUS:   next_dat = {22'h0, gp_or_terminal_ready_pin_i, dcd_in, ri_in, cts_on, dsr_on,
                                dsr_prev, 1'b0, state};
      ADR_IRQ_STAT: next_dat = {26'h0, ev_stat};
      ADR_IRQ_EN:   next_dat = {26'h0, ev_en};
      ADR_GPIO:     next_dat = {24'h0, gpio};
      default:      next_dat = 32'h0;
    endcase
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl     <= CTRL_RESET;
      map      <= MAP_RESET;
      retry_ms <= RETRY_RESET_MS;
      drop_ms  <= DROP_RESET_MS;
      peer_id  <= 8'h0;
      gpio     <= 8'h0;
      ev_stat  <= '0;
      ev_en    <= '0;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      map      <= next_map;
      retry_ms <= next_retry_ms;
      drop_ms  <= next_drop_ms;
      peer_id  <= next_peer_id;
      gpio     <= next_gpio;
      ev_stat  <= next_ev_stat;
      ev_en    <= next_ev_en;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      irq      <= |(next_ev_stat & next_ev_en);
    end
  end
endmodule // hmsc_top
`default_nettype wire

// >>> verif/hmsc_chk.sv
// Port checker for the modem signal control block
`timescale 1ns/1ps
`default_nettype none
module hmsc_chk
  import hmsc_pkg::*;
#(
  parameter int BREAK_LEN = BREAK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic host_presence_pin_n,
  input wire logic request_to_send_n,
  input wire logic rx_line,
  input wire logic rx_room,
  input wire logic serial_carrier_line_o,
  input wire logic serial_carrier_line_oe_n,
  input wire logic link_up,
  input wire logic link_open,
  input wire logic break_forward,
  input wire logic full_reset
);
  localparam int FIRE_MAX = 8;
  int low_cnt;
  int next_low_cnt;
  // Raw low run, ahead of the design's synced view
  always_comb next_low_cnt = rx_line ? 0 : low_cnt + 1;
  always_ff @(posedge clk) low_cnt <= next_low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rts_room: assert property (!$past(reset) |-> request_to_send_n == !$past(rx_room))
    else $error("request line not following receiver room");
  a_break_quiet: assert property (!break_forward)
    else $error("break forwarded to peer");
  a_break_run: assert property ($rose(full_reset) |-> $past(low_cnt, 2) >= BREAK_LEN)
    else $error("reset without unbroken low run");
  a_break_fires: assert property (low_cnt == BREAK_LEN + 2 |-> ##[0:FIRE_MAX] full_reset)
    else $error("long break gave no reset");
  a_open_dsr: assert property (link_open |-> !$past(host_presence_pin_n, 3) || !$past(host_presence_pin_n, 4))
    else $error("link opened without set-ready");
  a_carrier_idle: assert property ((!link_up && !serial_carrier_line_oe_n) [*3] |-> serial_carrier_line_o)
    else $error("carrier asserted without link");
endmodule // hmsc_chk
bind hmsc_top hmsc_chk #(.BREAK_LEN(BREAK_LEN)) u_chk (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .host_presence_pin_n, .request_to_send_n, .rx_line, .rx_room, .serial_carrier_line_o,
  .serial_carrier_line_oe_n, .link_up, .link_open, .break_forward, .full_reset);
`default_nettype wire

// >>> verif/hmsc_host_model.sv
// Host terminal model: set-ready, clear-to-send and receive line
`timescale 1ns/1ps
`default_nettype none
module hmsc_host_model (
  input  wire logic clk,
  input  wire logic dsr_on,
  input  wire logic cts_on,
  input  wire logic brk,
  input  wire logic send,
  input  wire logic rts_n,
  output logic      dsr_n = 1'b1,
  output logic      cts_n = 1'b1,
  output logic      rx = 1'b1
);
  logic [3:0] pat = 4'h5;
  always_ff @(posedge clk) begin
    dsr_n <= !dsr_on;
    cts_n <= !cts_on;
    pat   <= {pat[2:0], pat[3]};
    // Data only while the device grants it; break overrides
    rx    <= brk ? 1'b0 : (send && !rts_n) ? pat[0] : 1'b1;
  end
endmodule // hmsc_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the modem signal control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hmsc_pkg::*;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} hmsc_row_t;
  localparam int BLEN = 50; // Short break keeps the run brief
  logic        clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0, link_incoming_id = 8'h5a;
  logic [3:0]  wb_sel_i = 4'hf, remote_bits = 4'h0, local_bits;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, rx_room = 1'b1, link_incoming = 1'b0, link_up = 1'b0, link_fail = 1'b0;
  logic        osc_tick = 1'b1, dsr_on = 1'b0, cts_on = 1'b0, brk = 1'b0, send = 1'b0, osc_prev = 1'b0;
  logic        host_presence_pin_n, clear_to_send_n, request_to_send_n, rx_line;
  logic        ring_o, ring_oe_n, carr_o, carr_oe_n, gp_o, gp_oe_n, osc_out, irq, full_reset;
  logic        link_open, link_close, link_accept, break_forward, tx_allowed;
  wire         ring_w = ring_oe_n ? 1'b1 : ring_o; // Pull-ups when undriven
  wire         carr_w = carr_oe_n ? 1'b1 : carr_o;
  wire         gp_w = gp_oe_n ? 1'b1 : gp_o;
  int          bad_count = 0, checks_done = 0, opens = 0, closes = 0, accepts = 0, resets = 0, fwds = 0;
  int          rises = 0;
  hmsc_row_t   rows [12] = '{
    '{1'b0, ADR_CTRL, 32'h0, CTRL_RESET}, '{1'b0, ADR_MAP, 32'h0, MAP_RESET},
    '{1'b0, ADR_RETRY, 32'h0, {16'h0, RETRY_RESET_MS}}, '{1'b0, ADR_DROP, 32'h0, 32'h0},
    '{1'b0, ADR_IRQ_STAT, 32'h0, 32'h0}, '{1'b1, ADR_RETRY, 32'h3a98, 32'h0},
    '{1'b0, ADR_RETRY, 32'h0, 32'h3a98}, '{1'b1, ADR_RETRY, 32'h64, 32'h0},
    '{1'b0, ADR_RETRY, 32'h0, 32'h64}, '{1'b1, 8'h40, 32'hffffffff, 32'h0},
    '{1'b0, 8'h40, 32'h0, 32'h0}, '{1'b0, ADR_IRQ_EN, 32'h0, 32'h0}};
  hmsc_top #(.BREAK_LEN(BLEN)) DUT (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_presence_pin_n, .clear_to_send_n, .request_to_send_n,
    .rx_line, .rx_room, .serial_ring_line_i(ring_w), .serial_ring_line_o(ring_o),
    .serial_ring_line_oe_n(ring_oe_n), .serial_carrier_line_i(carr_w), .serial_carrier_line_o(carr_o),
    .serial_carrier_line_oe_n(carr_oe_n), .gp_or_terminal_ready_pin_i(gp_w),
    .gp_or_terminal_ready_pin_o(gp_o), .gp_or_terminal_ready_pin_oe_n(gp_oe_n), .link_incoming,
    .link_incoming_id, .link_up, .link_fail, .remote_bits, .local_bits, .link_open, .link_close,
    .link_accept, .break_forward, .tx_allowed, .osc_tick, .osc_out, .irq, .full_reset);
  hmsc_host_model u_host (.clk, .dsr_on, .cts_on, .brk, .send, .rts_n(request_to_send_n),
    .dsr_n(host_presence_pin_n), .cts_n(clear_to_send_n), .rx(rx_line));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    opens   += int'(link_open === 1'b1);
    closes  += int'(link_close === 1'b1);
    accepts += int'(link_accept === 1'b1);
    resets  += int'(full_reset === 1'b1);
    fwds    += int'(break_forward !== 1'b0);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      test_done();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    $display("watchdog expired");
    bad_count++;
    test_done();
  end
  initial begin
    tick(16);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) chk("register", q, rows[i].e);
    end
    $display("test registers done");
    wb(1'b1, ADR_IRQ_EN, 32'h1);
    for (int i = CMD_CONNECT; i <= CMD_DISCOVER; i++) begin
      wb(1'b1, ADR_IRQ_CLR, 32'h3f);
      wb(1'b1, ADR_CMD, 32'h1 << i);
      wb(1'b0, ADR_IRQ_STAT, 32'h0);
      chk("refused", q[EV_ERROR], 1'b1);
      chk("irq raised", irq, 1'b1);
    end
    chk("no open", opens, 32'h0);
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    tick(2);
    chk("irq masked", irq, 1'b0);
    wb(1'b1, ADR_IRQ_CLR, 32'h3f);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    chk("cleared", q, 32'h0);
    $display("test refusal done");
    dsr_on <= 1'b1;
    cts_on <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h3);
    tick(4);
    chk("pins driven", {ring_oe_n, carr_oe_n}, 32'h0);
    chk("cts seen", tx_allowed, 1'b1);
    chk("no carrier", carr_w, 1'b1);
    wb(1'b1, ADR_CMD, 32'h1);
    tick(2);
    chk("open", opens, 32'h1);
    link_up <= 1'b1;
    tick(4);
    chk("carrier", carr_w, 1'b0);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("data state", q[2:0], HMSC_DATA);
    remote_bits <= 4'h1;
    tick(3);
    chk("map direct", local_bits, 32'h1);
    wb(1'b1, ADR_MAP, 32'h1b);
    tick(3);
    chk("map swapped", local_bits, 32'h8);
    dsr_on <= 1'b0;
    tick(6);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("command state", q[2:0], HMSC_COMMAND);
    chk("still carrier", carr_w, 1'b0);
    wb(1'b1, ADR_CMD, 32'h1 << CMD_HANGUP);
    link_up <= 1'b0;
    tick(4);
    chk("hang up", closes, 32'h1);
    chk("carrier gone", carr_w, 1'b1);
    $display("test connection done");
    dsr_on <= 1'b1;
    link_incoming <= 1'b1;
    tick(4);
    chk("ring", ring_w, 1'b0);
    link_up <= 1'b1;
    wb(1'b1, ADR_CMD, 32'h1 << CMD_ANSWER);
    tick(2);
    chk("accepted", accepts, 32'h1);
    link_incoming <= 1'b0;
    tick(4);
    chk("ring off", ring_w, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h4);
    tick(2);
    chk("fifth pin", {gp_oe_n, gp_w}, 32'h0);
    wb(1'b1, ADR_CMD, 32'h1 << CMD_HANGUP);
    link_up <= 1'b0;
    tick(4);
    chk("fifth idle", gp_w, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h20);
    wb(1'b1, ADR_DROP, 32'h0033_0000);
    link_incoming <= 1'b1;
    tick(4);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("foreign peer", q[2:0], HMSC_IDLE);
    link_incoming_id <= 8'h33;
    tick(2);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("known peer", q[2:0], HMSC_RINGING);
    link_incoming <= 1'b0;
    $display("test ring done");
    brk <= 1'b1;
    tick(BLEN - 10);
    brk <= 1'b0;
    tick(5);
    chk("short break", resets, 32'h0);
    brk <= 1'b1;
    tick(BLEN + 10);
    brk <= 1'b0;
    chk("long break", resets != 0, 1'b1);
    chk("no forward", fwds, 32'h0);
    rx_room <= 1'b0;
    send <= 1'b1;
    tick(3);
    chk("rts off", request_to_send_n, 1'b1);
    rx_room <= 1'b1;
    tick(3);
    chk("rts on", request_to_send_n, 1'b0);
    send <= 1'b0;
    $display("test lines done");
    for (int s = 0; s < 4; s += 2) begin
      wb(1'b1, ADR_CTRL, {22'h0, 2'(s), 8'h80});
      tick(4);
      rises = 0;
      repeat (60) begin
        osc_prev = osc_out;
        @(posedge clk);
        rises += int'(osc_out === 1'b1 && osc_prev === 1'b0);
      end
      chk("osc rises", rises, (s == 0) ? 32'ha : 32'h1e);
    end
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl after reset", q, CTRL_RESET);
    chk("osc after reset", osc_out, 1'b0);
    $display("test osc done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
